// File: edpc_pkg.sv
// package of constants and types for the energy-detect power control block
////////////////////////////////////////////////////////////////////////////////
// Contract
// - burst enabled: send four energy-detect pulses each transmitter power-up
// - burst-disable bit 11 set: send exactly one pulse per power-up
// - read-only bit 10 shows power state, one is up, resets zero
// - bit 9 sets when error count reaches threshold, clears on read, no action
// - bit 8 sets when data count meets or exceeds threshold, clears on read
// - bits 7:4 read-write error threshold, reset 0001
// - bits 3:0 read-write data threshold, reset 0001
// - counters clear after about two seconds with no data event
// - bit 15 enable, reset zero; when clear no power sequencing runs
// - auto power-up (default on) starts up sequence at data threshold
// - auto power-down (default on) starts down sequence when no energy
// - writing one to manual bit forces state change; bit self-clears
package edpc_pkg;

  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;

  localparam int BIT_ENABLE = 15;
  localparam int BIT_AUTO_UP = 14;
  localparam int BIT_AUTO_DOWN = 13;
  localparam int BIT_MANUAL = 12;
  localparam int BIT_BURST_DIS = 11;
  localparam int BIT_PWR_STATE = 10;
  localparam int BIT_ERR_MET = 9;
  localparam int BIT_DATA_MET = 8;

  localparam logic [3:0] RST_THRESHOLD = 4'h1;
  localparam logic [15:0] RST_CONTROL = 16'h6011;

  localparam int IRQ_W = 3;
  localparam int IRQ_DATA_MET = 0;
  localparam int IRQ_ERR_MET = 1;
  localparam int IRQ_PWR_CHANGE = 2;

  localparam int BURST_PULSES = 4;
  localparam int CLK_HZ = 20000000;
  localparam int QUIET_SECONDS = 2;
  localparam int QUIET_CYCLES = CLK_HZ * QUIET_SECONDS;

  typedef struct packed {
    logic energy_sense_enable;
    logic auto_power_up;
    logic auto_power_down;
    logic pulse_burst_disable;
    logic [3:0] error_event_threshold;
    logic [3:0] data_event_threshold;
  } edpc_cfg_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } edpc_req_s;

endpackage

// File: edpc_pulse_gen.sv
// pulse burst generator fired on each transmitter power-up
module edpc_pulse_gen #(
  parameter int BURST = edpc_pkg::BURST_PULSES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic start_i,
  input wire logic single_i,
  // pulse out
  output logic pulse_o
);
  logic [3:0] left;
  logic gap;
  wire logic fire = (left != 4'h0) && !gap;

  // a low cycle between pulses keeps each pulse separately visible
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      left <= 4'h0;
      gap <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= fire;
      gap <= fire;
      if (start_i) begin
        left <= single_i ? 4'h1 : 4'(BURST);
        gap <= 1'b0;
      end else if (fire) begin
        left <= left - 4'h1;
      end
    end
  end
endmodule

// File: edpc_ctrl.sv
// energy-detect control and status register with power sequencing
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
module edpc_ctrl #(
  parameter int QUIET_CYCLES = edpc_pkg::QUIET_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // line events
  input wire logic data_event_i,
  input wire logic error_event_i,
  input wire logic energy_present_i,
  // power, pulses and interrupt
  output logic power_up_o,
  output logic tx_pulse_o,
  output logic irq_o
);
  edpc_pkg::edpc_cfg_s cfg;
  logic pwr_state;
  logic err_met;
  logic data_met;
  logic [3:0] err_cnt;
  logic [3:0] data_cnt;
  logic [31:0] quiet_cnt;
  logic [edpc_pkg::IRQ_W-1:0] irq_status;
  logic [edpc_pkg::IRQ_W-1:0] irq_enable;
  logic pulse_start;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic wr_ctrl = wr_i && (addr_i == edpc_pkg::ADDR_CONTROL);
  wire logic rd_ctrl = rd_i && (addr_i == edpc_pkg::ADDR_CONTROL);
  wire logic wr_ien = wr_i && (addr_i == edpc_pkg::ADDR_IRQ_ENABLE);
  wire logic wr_iclr = wr_i && (addr_i == edpc_pkg::ADDR_IRQ_CLEAR);
  wire logic manual = wr_ctrl && wdata_i[edpc_pkg::BIT_MANUAL];
  wire logic quiet_hit = (quiet_cnt >= 32'(QUIET_CYCLES - 1));
  wire logic [3:0] next_err_cnt = (err_cnt == 4'hf) ? err_cnt : err_cnt + 4'h1;
  wire logic [3:0] next_data_cnt = (data_cnt == 4'hf) ? data_cnt : data_cnt + 4'h1;
  wire logic err_reach = error_event_i && (next_err_cnt >= cfg.error_event_threshold);
  wire logic data_reach = data_event_i && (next_data_cnt >= cfg.data_event_threshold);
  // sequencing only while enabled
  wire logic go_up = cfg.energy_sense_enable && !pwr_state &&
                     (manual || (cfg.auto_power_up && data_reach));
  wire logic go_down = cfg.energy_sense_enable && pwr_state &&
                       (manual || (cfg.auto_power_down && !energy_present_i));
  wire logic [edpc_pkg::IRQ_W-1:0] irq_set = {go_up || go_down, err_reach, data_reach};

  wire logic [15:0] ctrl_view = {cfg.energy_sense_enable, cfg.auto_power_up, cfg.auto_power_down, 1'b0,
                                 cfg.pulse_burst_disable, pwr_state, err_met, data_met,
                                 cfg.error_event_threshold, cfg.data_event_threshold};
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        edpc_pkg::ADDR_CONTROL: next_rdata = ctrl_view;
        edpc_pkg::ADDR_IRQ_STATUS: next_rdata = {13'h0000, irq_status};
        edpc_pkg::ADDR_IRQ_ENABLE: next_rdata = {13'h0000, irq_enable};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration register; manual bit is a pulse and never stored
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg <= edpc_pkg::edpc_cfg_s'({1'b0, 1'b1, 1'b1, 1'b0, edpc_pkg::RST_THRESHOLD,
                                    edpc_pkg::RST_THRESHOLD});
    end else if (wr_ctrl) begin
      cfg <= edpc_pkg::edpc_cfg_s'({wdata_i[15:13], wdata_i[11], wdata_i[7:0]});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event counters and quiet timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_cnt <= 4'h0;
      data_cnt <= 4'h0;
      quiet_cnt <= 32'h0;
    end else if (data_event_i) begin
      quiet_cnt <= 32'h0;
      data_cnt <= next_data_cnt;
      err_cnt <= error_event_i ? next_err_cnt : err_cnt;
    end else if (quiet_hit) begin
      quiet_cnt <= 32'h0;
      err_cnt <= 4'h0;
      data_cnt <= 4'h0;
    end else begin
      quiet_cnt <= quiet_cnt + 32'h1;
      err_cnt <= error_event_i ? next_err_cnt : err_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags: a new hit in a read cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_met <= 1'b0;
      data_met <= 1'b0;
    end else begin
      err_met <= err_reach || (err_met && !rd_ctrl);
      data_met <= data_reach || (data_met && !rd_ctrl);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state; error threshold never moves it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr_state <= 1'b0;
      pulse_start <= 1'b0;
    end else begin
      pulse_start <= go_up;
      if (go_up) begin
        pwr_state <= 1'b1;
      end else if (go_down) begin
        pwr_state <= 1'b0;
      end
    end
  end

  edpc_pulse_gen #(
    .BURST(edpc_pkg::BURST_PULSES)
  ) u_pulse (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(pulse_start),
    .single_i(cfg.pulse_burst_disable),
    .pulse_o(tx_pulse_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt and read port
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq_o <= 1'b0;
      rdata_o <= 16'h0000;
      power_up_o <= 1'b0;
    end else begin
      irq_status <= irq_set | (irq_status & ~(wr_iclr ? wdata_i[edpc_pkg::IRQ_W-1:0] : '0));
      if (wr_ien) begin
        irq_enable <= wdata_i[edpc_pkg::IRQ_W-1:0];
      end
      irq_o <= |(irq_status & irq_enable);
      rdata_o <= next_rdata;
      power_up_o <= pwr_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_flag_hold;
    @(posedge clk_i) disable iff (sys_rst_i) data_met && !rd_ctrl |=> data_met;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("data flag lost without read");
  property p_data_set;
    @(posedge clk_i) disable iff (sys_rst_i) data_reach |=> data_met;
  endproperty
  a_data_set: assert property (p_data_set) else $error("data flag not set");
  property p_err_set;
    @(posedge clk_i) disable iff (sys_rst_i) err_reach |=> err_met;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");
  property p_rd_clear;
    @(posedge clk_i) disable iff (sys_rst_i) rd_ctrl && !err_reach |=> !err_met;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("error flag not cleared by read");
  property p_disabled;
    @(posedge clk_i) disable iff (sys_rst_i) !cfg.energy_sense_enable |=> $stable(pwr_state);
  endproperty
  a_disabled: assert property (p_disabled) else $error("power moved while disabled");
  // burst mode as the pulse generator will see it one edge later, a write in the same cycle included
  wire logic single_next = wr_ctrl ? wdata_i[edpc_pkg::BIT_BURST_DIS] : cfg.pulse_burst_disable;
  // start is registered and the generator registers again, so the first pulse is seen three edges on
  property p_burst;
    @(posedge clk_i) disable iff (sys_rst_i)
      go_up && !single_next |=> ##2 tx_pulse_o ##1 !tx_pulse_o ##1 tx_pulse_o ##1 !tx_pulse_o ##1 tx_pulse_o
      ##1 !tx_pulse_o ##1 tx_pulse_o ##1 !tx_pulse_o;
  endproperty
  a_burst: assert property (p_burst) else $error("burst of pulses wrong");
  property p_single;
    @(posedge clk_i) disable iff (sys_rst_i)
      go_up && single_next |=> ##2 tx_pulse_o ##1 !tx_pulse_o [*6];
  endproperty
  a_single: assert property (p_single) else $error("single pulse wrong");
  property p_manual;
    @(posedge clk_i) disable iff (sys_rst_i) manual && cfg.energy_sense_enable |=> pwr_state != $past(pwr_state);
  endproperty
  a_manual: assert property (p_manual) else $error("manual toggle ignored");
  property p_rd_state;
    @(posedge clk_i) disable iff (sys_rst_i) rd_ctrl |=> rdata_o[edpc_pkg::BIT_PWR_STATE] == $past(pwr_state);
  endproperty
  a_rd_state: assert property (p_rd_state) else $error("power state read wrong");

  property p_manual_zero;
    @(posedge clk_i) disable iff (sys_rst_i) rd_ctrl |=> !rdata_o[edpc_pkg::BIT_MANUAL];
  endproperty
  a_manual_zero: assert property (p_manual_zero) else $error("manual bit read back set");

  property p_err_no_action;
    @(posedge clk_i) disable iff (sys_rst_i) err_reach && !go_up && !go_down |=> $stable(pwr_state);
  endproperty
  a_err_no_action: assert property (p_err_no_action) else $error("error threshold moved power");

  property p_quiet_clear;
    @(posedge clk_i) disable iff (sys_rst_i) quiet_hit && !data_event_i |=> data_cnt == 4'h0 && err_cnt == 4'h0;
  endproperty
  a_quiet_clear: assert property (p_quiet_clear) else $error("counters not cleared after quiet");

  property p_auto_up;
    @(posedge clk_i) disable iff (sys_rst_i) go_up |=> pwr_state ##1 power_up_o;
  endproperty
  a_auto_up: assert property (p_auto_up) else $error("power-up not taken");

  property p_auto_down;
    @(posedge clk_i) disable iff (sys_rst_i) go_down |=> !pwr_state ##1 !power_up_o;
  endproperty
  a_auto_down: assert property (p_auto_down) else $error("power-down not taken");

  property p_err_thr_wr;
    @(posedge clk_i) disable iff (sys_rst_i) wr_ctrl |=> cfg.error_event_threshold == $past(wdata_i[7:4]);
  endproperty
  a_err_thr_wr: assert property (p_err_thr_wr) else $error("error threshold not written");

  property p_data_thr_wr;
    @(posedge clk_i) disable iff (sys_rst_i) wr_ctrl |=> cfg.data_event_threshold == $past(wdata_i[3:0]);
  endproperty
  a_data_thr_wr: assert property (p_data_thr_wr) else $error("data threshold not written");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (sys_rst_i) !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  c_manual: cover property (@(posedge clk_i) disable iff (sys_rst_i) manual && single_next && go_up);
  c_up: cover property (@(posedge clk_i) disable iff (sys_rst_i) go_up && !manual);
  c_down: cover property (@(posedge clk_i) disable iff (sys_rst_i) go_down && !manual);
  c_quiet: cover property (@(posedge clk_i) disable iff (sys_rst_i) quiet_hit && data_cnt != 4'h0);
  c_irq: cover property (@(posedge clk_i) disable iff (sys_rst_i) irq_o);
endmodule

// File: edpc_ctrl_bench.sv
// self-checking bench for the energy-detect control register block
module edpc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rd_val, ctl;
  logic data_event_i = 0, error_event_i = 0, energy_present_i = 1;
  wire logic [15:0] rdata_o;
  wire logic power_up_o, tx_pulse_o, irq_o;
  int num_errors = 0, check_count = 0, pulses = 0, thr_d, thr_e;

  // short quiet window keeps the counter-clear test inside the run budget
  edpc_ctrl #(.QUIET_CYCLES(50)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_event_i(data_event_i),
    .error_event_i(error_event_i), .energy_present_i(energy_present_i), .power_up_o(power_up_o),
    .tx_pulse_o(tx_pulse_o), .irq_o(irq_o));

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (tx_pulse_o === 1'b1) pulses++;

  ////////////////////////////////////////
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    rd_val = rdata_o;
  endtask
  task ev(input logic err);
    @(posedge clk_i);
    if (err) error_event_i <= 1'b1;
    else data_event_i <= 1'b1;
    @(posedge clk_i);
    error_event_i <= 1'b0;
    data_event_i <= 1'b0;
  endtask
  task wait_pwr(input logic exp);
    int n;
    n = 0;
    while (power_up_o !== exp && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      $display("ERROR power_up_o expected %b seen %b", exp, power_up_o);
      end_sim();
    end
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(97708));
    thr_d = 2 + $urandom % 3;
    thr_e = 1 + $urandom % 3;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(4'h0);
    chk("control reset", rd_val, 16'h6011);
    rd(4'h2);
    chk("irq enable reset", rd_val, 16'h0000);
    rd(4'h7);
    chk("unmapped read", rd_val, 16'h0000);
    // power state is compared while the function is disabled: a data event must leave it down
    ev(1'b0);
    repeat (4) @(negedge clk_i);
    chk("power_up_o disabled", {15'h0000, power_up_o}, 16'h0000);
    rd(4'h0);
    repeat (60) @(posedge clk_i);
    ctl = 16'he000 | 16'(thr_e << 4) | 16'(thr_d);
    wr(4'h0, ctl | 16'h0700);
    rd(4'h0);
    chk("control rw", rd_val, ctl);
    wr(4'h2, 16'h0001);
    pulses = 0;
    repeat (thr_d - 1) ev(1'b0);
    rd(4'h0);
    chk("below threshold", rd_val, ctl);
    ev(1'b0);
    wait_pwr(1'b1);
    repeat (12) @(negedge clk_i);
    chk("burst pulses", 16'(pulses), 16'h0004);
    chk("irq raised", {15'h0000, irq_o}, 16'h0001);
    // counters clear meanwhile, the flag must survive
    repeat (60) @(posedge clk_i);
    rd(4'h0);
    chk("data met held", rd_val, ctl | 16'h0500);
    rd(4'h0);
    chk("clear on read", rd_val, ctl | 16'h0400);
    rd(4'h1);
    chk("irq status", rd_val, 16'h0005);
    wr(4'h3, 16'h0007);
    rd(4'h1);
    chk("irq status cleared", rd_val, 16'h0000);
    chk("irq dropped", {15'h0000, irq_o}, 16'h0000);
    ev(1'b0);
    repeat (thr_e) ev(1'b1);
    rd(4'h0);
    chk("error met", rd_val, ctl | 16'h0600);
    @(posedge clk_i);
    energy_present_i <= 1'b0;
    wait_pwr(1'b0);
    // manual toggle with auto power-down off and a single pulse
    ctl = (ctl & 16'hdfff) | 16'h0800;
    wr(4'h0, ctl);
    pulses = 0;
    wr(4'h0, ctl | 16'h1000);
    wait_pwr(1'b1);
    repeat (12) @(negedge clk_i);
    chk("single pulse", 16'(pulses), 16'h0001);
    rd(4'h0);
    chk("manual self-clear", rd_val, ctl | 16'h0400);
    repeat (60) @(posedge clk_i);
    repeat (thr_d - 1) ev(1'b0);
    repeat (60) @(posedge clk_i);
    ev(1'b0);
    rd(4'h0);
    chk("quiet clears count", rd_val, ctl | 16'h0400);
    repeat (thr_d - 1) ev(1'b0);
    rd(4'h0);
    chk("count after quiet", rd_val, ctl | 16'h0500);
    end_sim();
  end
endmodule
